// [src/mpsc_top.sv]
/*
  Sleep, run and fault control with command watchdog and gate drive PWM.
  Assumes analog front ends supply comparator levels and a digitised duty.
*/
// What this block does
// - Gate drive output stays low throughout the sleep state.
// - Any valid speed command moves the device from sleep to run, or to fault under overvoltage.
// - Overvoltage or overcurrent sends the device into the fault state.
// - The command input is active low; its low part is asserted.
// - Command counts as active only if pulsed within every 2048 oscillator counts.
// - A high manual-mode input selects manual command mode.
// - Auto or manual mode is chosen internally from input levels alone.
// - Auto mode accepts command duty from 0% up to 100%.
// - Gate PWM has fixed frequency, variable duty, and reaches 100% on.
// - Switched reference is connected to the regulated supply only in run.
// - Current sense above the limit reference raises an overcurrent trip.
// - In auto mode a command stuck 2048 oscillator cycles returns to sleep.
// - Fault exits to run when overvoltage clears; current fault needs sleep.
// - In auto mode a falling command edge wakes the device into run, or into fault under overvoltage.
// - In manual mode losing the high manual input enters sleep.
`timescale 1ns/1ps
`include "mpsc_consts.svh"
module mpsc_top (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic                      COMMAND_IN_N,
  input  wire logic                      MANUAL_MODE_IN,
  input  wire logic                      OVERVOLTAGE_IN,
  input  wire logic [`MPSC_DUTY_W-1:0]   CURRENT_SENSE_IN,
  input  wire logic [`MPSC_DUTY_W-1:0]   CURRENT_LIMIT_REFERENCE,
  input  wire logic [`MPSC_DUTY_W-1:0]   DUTY_IN,
  output logic                           GATE_DRIVE_OUT,
  output logic                           SWITCHED_REFERENCE_OUT,
  output logic                           COMMAND_PULLUP_OUT,
  output logic                           CURRENT_FAULT_OUT,
  output logic                           COMMAND_ACTIVE_OUT,
  output mpsc_pkg::mpsc_state_e          STATE_OUT
);
  import mpsc_pkg::*;

  mpsc_sync_if sif ();

  logic                      cmd_n;
  logic                      man;
  logic                      ov;
  logic                      trip;
  logic                      auto_mode;
  logic                      cmd_prev;
  logic                      cmd_fall;
  logic                      cmd_edge;
  logic                      osc_tick;
  logic [`MPSC_DIV_W-1:0]    div_cnt;
  logic [`MPSC_DIV_W-1:0]    next_div_cnt;
  logic [`MPSC_IDLE_W-1:0]   idle_cnt;
  logic [`MPSC_IDLE_W-1:0]   next_idle_cnt;
  logic                      cmd_idle;
  logic [`MPSC_DUTY_W-1:0]   ramp;
  logic [`MPSC_DUTY_W-1:0]   next_ramp;
  logic [`MPSC_DUTY_W-1:0]   duty;
  logic [`MPSC_DUTY_W-1:0]   next_duty;
  mpsc_state_e               state;
  mpsc_state_e               next_state;
  logic                      run_manual;
  logic                      next_run_manual;
  logic                      cur_fault;
  logic                      next_cur_fault;
  logic                      sleep_cond;
  logic                      gate;
  logic                      next_gate;

  // The current comparison is resolved before the synchroniser so only one bit crosses.
  // The command crosses as its asserted level, so an idle high pin matches the cleared stages after reset.
  assign sif.raw[`MPSC_SYNC_CMD]  = !COMMAND_IN_N;
  assign sif.raw[`MPSC_SYNC_MAN]  = MANUAL_MODE_IN;
  assign sif.raw[`MPSC_SYNC_OV]   = OVERVOLTAGE_IN;
  assign sif.raw[`MPSC_SYNC_TRIP] = CURRENT_SENSE_IN > CURRENT_LIMIT_REFERENCE;

  mpsc_sync #(
    .WIDTH (`MPSC_SYNC_W)
  ) u_sync (
    .clk (CLK),
    .rst (RST),
    .bus (sif)
  );

  assign cmd_n     = !sif.clean[`MPSC_SYNC_CMD];
  assign man       = sif.clean[`MPSC_SYNC_MAN];
  assign ov        = sif.clean[`MPSC_SYNC_OV];
  assign trip      = sif.clean[`MPSC_SYNC_TRIP];
  assign auto_mode = !man;
  assign cmd_fall  = cmd_prev && !cmd_n;
  assign cmd_edge  = cmd_prev != cmd_n;
  assign osc_tick  = div_cnt == `MPSC_DIV_W'(`MPSC_OSC_DIV - 1);
  assign cmd_idle  = idle_cnt == `MPSC_IDLE_TICKS;

  // Oscillator-rate enable and command activity watchdog.
  always_comb begin
    next_div_cnt  = osc_tick ? '0 : div_cnt + `MPSC_DIV_W'(1);
    next_idle_cnt = idle_cnt;
    if (!auto_mode || cmd_edge) begin
      next_idle_cnt = '0;
    end else if (osc_tick && !cmd_idle) begin
      next_idle_cnt = idle_cnt + `MPSC_IDLE_W'(1);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_cnt  <= '0;
      idle_cnt <= '0;
      cmd_prev <= 1'b1;
    end else begin
      div_cnt  <= next_div_cnt;
      idle_cnt <= next_idle_cnt;
      cmd_prev <= cmd_n;
    end
  end

  // Sleep is taken from whichever command path started the run.
  assign sleep_cond = run_manual ? !man : cmd_idle;

  always_comb begin
    next_state      = state;
    next_run_manual = run_manual;
    next_cur_fault  = cur_fault;
    unique case (state)
      MPSC_SLEEP: begin
        next_cur_fault = 1'b0;
        if (man || cmd_fall) begin
          next_run_manual = man;
          next_state      = ov ? MPSC_FAULT : MPSC_RUN;
        end
      end
      MPSC_RUN: begin
        if (trip) begin
          next_cur_fault = 1'b1;
        end
        if (sleep_cond) begin
          next_state = MPSC_SLEEP;
        end else if (ov || trip) begin
          next_state = MPSC_FAULT;
        end
      end
      MPSC_FAULT: begin
        if (sleep_cond) begin
          next_state = MPSC_SLEEP;
        end else if (!ov && !cur_fault) begin
          next_state = MPSC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state      <= MPSC_SLEEP;
      run_manual <= 1'b0;
      cur_fault  <= 1'b0;
    end else begin
      state      <= next_state;
      run_manual <= next_run_manual;
      cur_fault  <= next_cur_fault;
    end
  end

  // Duty is sampled once per period so a mid-period change cannot chop a pulse.
  // A duty of all ones never meets the ramp and so holds the gate fully on.
  always_comb begin
    next_ramp = (ramp == `MPSC_PWM_TOP) ? '0 : ramp + `MPSC_DUTY_W'(1);
    next_duty = (ramp == `MPSC_PWM_TOP) ? DUTY_IN : duty;
    next_gate = (next_state == MPSC_RUN) && (duty > ramp);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ramp <= '0;
      duty <= '0;
      gate <= 1'b0;
    end else begin
      ramp <= next_ramp;
      duty <= next_duty;
      gate <= next_gate;
    end
  end

  assign GATE_DRIVE_OUT         = gate;
  assign SWITCHED_REFERENCE_OUT = state == MPSC_RUN;
  assign COMMAND_PULLUP_OUT     = auto_mode && state != MPSC_SLEEP;
  assign CURRENT_FAULT_OUT      = cur_fault;
  assign COMMAND_ACTIVE_OUT     = auto_mode && !cmd_idle;
  assign STATE_OUT              = state;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_sleep_gate_low;
    state == MPSC_SLEEP |-> !GATE_DRIVE_OUT;
  endproperty
  a_sleep_gate_low: assert property (p_sleep_gate_low) else $error("Gate high in sleep.");

  property p_manual_wake;
    state == MPSC_SLEEP && man && !ov |=> state == MPSC_RUN && SWITCHED_REFERENCE_OUT;
  endproperty
  a_manual_wake: assert property (p_manual_wake) else $error("Manual command did not wake.");

  property p_fault_entry;
    state == MPSC_RUN && !sleep_cond && (ov || trip) |=> state == MPSC_FAULT;
  endproperty
  a_fault_entry: assert property (p_fault_entry) else $error("Fault not entered.");

  property p_auto_wake;
    state == MPSC_SLEEP && !man && $fell(cmd_n) && !ov |=> state == MPSC_RUN;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("Falling command edge did not wake.");

  property p_idle_sleep;
    state == MPSC_RUN && !run_manual && idle_cnt == `MPSC_IDLE_TICKS |=> state == MPSC_SLEEP;
  endproperty
  a_idle_sleep: assert property (p_idle_sleep) else $error("Idle command did not sleep.");

  property p_idle_bound;
    idle_cnt <= `MPSC_IDLE_TICKS;
  endproperty
  a_idle_bound: assert property (p_idle_bound) else $error("Watchdog count overran.");

  property p_reference_run;
    SWITCHED_REFERENCE_OUT == (state == MPSC_RUN);
  endproperty
  a_reference_run: assert property (p_reference_run) else $error("Reference switch wrong.");

  property p_fault_exit;
    state == MPSC_FAULT && !ov && !cur_fault && !sleep_cond |=> state == MPSC_RUN;
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("Fault did not exit to run.");

  property p_current_latch;
    state == MPSC_FAULT && cur_fault && !sleep_cond |=> state == MPSC_FAULT && cur_fault;
  endproperty
  a_current_latch: assert property (p_current_latch) else $error("Current fault left without sleep.");

  property p_edge_clears;
    cmd_edge || man |=> idle_cnt == '0;
  endproperty
  a_edge_clears: assert property (p_edge_clears) else $error("Watchdog not cleared.");

  property p_manual_drop;
    state == MPSC_RUN && run_manual && !man |=> state == MPSC_SLEEP;
  endproperty
  a_manual_drop: assert property (p_manual_drop) else $error("Manual drop did not sleep.");

  property p_trip_latch;
    state == MPSC_RUN && trip |=> cur_fault;
  endproperty
  a_trip_latch: assert property (p_trip_latch) else $error("Trip not latched.");

  property p_full_duty;
    state == MPSC_RUN && next_state == MPSC_RUN && duty == 8'hff |=> GATE_DRIVE_OUT;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("Full duty not held on.");
endmodule // mpsc_top

// [shared/mpsc_consts.svh]
/*
  Timing counts and field widths of the motor PWM state control block.
  Assumes a 10 MHz system clock and a 20 kHz nominal oscillator rate.
*/
`ifndef MPSC_CONSTS_SVH
`define MPSC_CONSTS_SVH

`define MPSC_CLK_FREQ_HZ   10000000
`define MPSC_OSC_FREQ_HZ   20000
`define MPSC_OSC_DIV       (`MPSC_CLK_FREQ_HZ / `MPSC_OSC_FREQ_HZ)
`define MPSC_DIV_W         9
`define MPSC_IDLE_TICKS    12'h800
`define MPSC_IDLE_W        12
`define MPSC_DUTY_W        8
`define MPSC_PWM_TOP       8'hfe
`define MPSC_SYNC_W        4
`define MPSC_SYNC_CMD      0
`define MPSC_SYNC_MAN      1
`define MPSC_SYNC_OV       2
`define MPSC_SYNC_TRIP     3

`endif

// [shared/mpsc_pkg.sv]
/*
  Types of the motor PWM state control block.
  Assumes mpsc_consts.svh holds all numeric constants.
*/
package mpsc_pkg;
  typedef enum logic [1:0] {
    MPSC_SLEEP,
    MPSC_RUN,
    MPSC_FAULT
  } mpsc_state_e;
endpackage

// [shared/mpsc_sync_if.sv]
/*
  Carries raw detector levels into the synchroniser and clean levels back.
  Assumes one clock domain on both sides.
*/
`timescale 1ns/1ps
`include "mpsc_consts.svh"
interface mpsc_sync_if;
  logic [`MPSC_SYNC_W-1:0] raw;
  logic [`MPSC_SYNC_W-1:0] clean;
  modport src  (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// [src/mpsc_sync.sv]
/*
  Three flip-flop synchroniser with agreement filter for detector levels.
  Assumes raw levels may change at any time relative to the clock.
*/
`timescale 1ns/1ps
`include "mpsc_consts.svh"
module mpsc_sync #(
  parameter int WIDTH = `MPSC_SYNC_W
) (
  input  wire logic  clk,
  input  wire logic  rst,
  mpsc_sync_if.sync  bus
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;
  logic [WIDTH-1:0] clean;
  logic [WIDTH-1:0] next_clean;

  // A new level is accepted only once the second and third stages agree.
  always_comb begin
    next_clean = clean;
    for (int i = 0; i < WIDTH; i++) begin
      if (ff2[i] == ff3[i]) begin
        next_clean[i] = ff3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ff1   <= '0;
      ff2   <= '0;
      ff3   <= '0;
      clean <= '0;
    end else begin
      ff1   <= bus.raw;
      ff2   <= ff1;
      ff3   <= ff2;
      clean <= next_clean;
    end
  end

  assign bus.clean = clean;
endmodule // mpsc_sync

// [bench/mpsc_far_model.sv]
/*
  Far side of the block: open-collector command source and the low-side transistor's drain sense.
  Assumes the bench steers the command switch and the load level.
*/
`timescale 1ns/1ps
`include "mpsc_consts.svh"
module mpsc_far_model (
  input  wire logic                    clk,
  input  wire logic                    gate,
  input  wire logic                    pull_en,
  input  wire logic                    src_pull,
  input  wire logic                    drive_low,
  input  wire logic [`MPSC_DUTY_W-1:0] load,
  output logic                         cmd_n,
  output logic [`MPSC_DUTY_W-1:0]      sense
);
  logic float_lvl = 1'b1;
  // A released, unpulled line shows the inverse of its last level, so a stale level is never trusted.
  always @(posedge clk) begin
    if (drive_low || pull_en || src_pull) begin
      float_lvl <= ~cmd_n;
    end
  end
  // The source's own resistor keeps the line high in sleep, where the device removes its pull-up.
  assign cmd_n = drive_low ? 1'b0 : ((pull_en || src_pull) ? 1'b1 : float_lvl);
  // Drain sense rises with conduction only, so an idle transistor never trips.
  assign sense = gate ? load : '0;
endmodule // mpsc_far_model

// [bench/motor_pwm_state_control_tb.sv]
/*
  Self-checking bench of the motor PWM state control block.
  Assumes the design files and the far-side model are compiled first.
*/
`timescale 1ns/1ps
`include "mpsc_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module motor_pwm_state_control_tb;
  import mpsc_pkg::*;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    man;
  logic                    ov;
  logic                    drive_low;
  logic                    pulse_en;
  logic [`MPSC_DUTY_W-1:0] duty;
  logic [`MPSC_DUTY_W-1:0] lim;
  logic [`MPSC_DUTY_W-1:0] load;
  logic [`MPSC_DUTY_W-1:0] sense;
  logic [`MPSC_DUTY_W-1:0] tbl [9];
  logic [8:0]              hi;
  logic                    cmd_n, gate, swref, pull_en, cfault, active;
  logic                    src_pull;
  logic                    pulse = 1'b0;
  mpsc_state_e             state;
  int                      error_cnt = 0;
  int                      cmp_count = 0;
  int                      seed;
  always #50 clk = ~clk;
  mpsc_top u_dut (.CLK(clk), .RST(rst), .COMMAND_IN_N(cmd_n), .MANUAL_MODE_IN(man), .OVERVOLTAGE_IN(ov),
    .CURRENT_SENSE_IN(sense), .CURRENT_LIMIT_REFERENCE(lim), .DUTY_IN(duty), .GATE_DRIVE_OUT(gate),
    .SWITCHED_REFERENCE_OUT(swref), .COMMAND_PULLUP_OUT(pull_en), .CURRENT_FAULT_OUT(cfault),
    .COMMAND_ACTIVE_OUT(active), .STATE_OUT(state));
  mpsc_far_model u_far (.clk(clk), .gate(gate), .pull_en(pull_en), .src_pull(src_pull),
    .drive_low(drive_low ^ pulse), .load(load), .cmd_n(cmd_n), .sense(sense));
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // A state that is not reached in time ends the run, since later checks would be meaningless.
  task automatic wait_state(input mpsc_state_e s, input int lim_c);
    int i;
    for (i = 0; i < lim_c && state !== s; i++) begin
      step(1);
    end
    cmp_count++;
    if (state !== s) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, state, s);
      final_report();
    end
  endtask
  function automatic logic [8:0] exp_high(input logic [`MPSC_DUTY_W-1:0] d);
    return (d == 8'hff) ? 9'h0ff : {1'b0, d};
  endfunction
  initial begin
    forever begin
      step(1500);
      if (pulse_en) begin
        pulse = ~pulse;
      end
    end
  end
  initial begin
    seed = 32'h631c4c08;
    man = 1'b1;
    ov = 1'b1;
    duty = 8'h00;
    lim = 8'h80;
    load = 8'h00;
    drive_low = 1'b0;
    src_pull = 1'b0;
    pulse_en = 1'b0;
    tbl = '{8'h00, 8'h01, 8'h80, 8'hfe, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    step(8);
    `CHK(state, MPSC_SLEEP)
    `CHK(gate, 1'b0)
    `CHK(swref, 1'b0)
    rst = 1'b0;
    wait_state(MPSC_FAULT, 20);
    step(10);
    ov = 1'b0;
    wait_state(MPSC_RUN, 20);
    `CHK(swref, 1'b1)
    `CHK(pull_en, 1'b0)
    `CHK(active, 1'b0)
    duty = 8'hff;
    load = 8'h90;
    wait_state(MPSC_FAULT, 600);
    `CHK(cfault, 1'b1)
    load = 8'h00;
    step(300);
    `CHK(state, MPSC_FAULT)
    src_pull = 1'b1;
    man = 1'b0;
    wait_state(MPSC_SLEEP, 20);
    step(3);
    `CHK(cfault, 1'b0)
    repeat (300) begin
      step(1);
      `CHK(gate, 1'b0)
    end
    `CHK(swref, 1'b0)
    drive_low = 1'b1;
    wait_state(MPSC_RUN, 20);
    `CHK(pull_en, 1'b1)
    `CHK(active, 1'b1)
    pulse_en = 1'b1;
    for (int i = 5; i < 9; i++) begin
      tbl[i] = 8'($random(seed));
    end
    for (int i = 0; i < 9; i++) begin
      duty = tbl[i];
      step(520);
      hi = '0;
      repeat (255) begin
        if (gate === 1'b1) begin
          hi++;
        end
        step(1);
      end
      `CHK(hi, exp_high(tbl[i]))
    end
    ov = 1'b1;
    wait_state(MPSC_FAULT, 20);
    `CHK(swref, 1'b0)
    ov = 1'b0;
    wait_state(MPSC_RUN, 20);
    final_report();
  end
endmodule // motor_pwm_state_control_tb
